// file: move_profile_defs.vh
// Constants shared by the move profile generator files.
// Included by bare name; definitions only.
`ifndef MOVE_PROFILE_DEFS_VH
`define MOVE_PROFILE_DEFS_VH
// Register byte offsets on the APB slave
`define REG_CTRL 8'h00
`define REG_TARGET 8'h04
`define REG_SPEED 8'h08
`define REG_ACCEL 8'h0C
`define REG_DECEL 8'h10
`define REG_JERK 8'h14
`define REG_START 8'h18
`define REG_STATUS 8'h1C
`define REG_POSITION 8'h20
`define REG_PRESET 8'h24
// Control register fields
`define CTRL_GO 0
`define CTRL_ABS 1
`define CTRL_PRESET 2
`define CTRL_CLR_ERR 3
// Status register fields
`define ST_BUSY 0
`define ST_ERR 1
`define ST_DIR 2
`define ST_HOMED 3
`define ST_CRUISE 4
// Ranges
`define TARGET_MAX 24'h7FFFFF
`define POS_MIN 32'hFE0C0000
`define POS_MAX 32'h01F3FFFF
`define JERK_MAX 16'h1388
`define START_MAX 21'h1E847F
`define ACCEL_SCALE 1000
`define JERK_SCALE 100
// Profile tick: 1 ms at 100 MHz
`define TICK_NS 1000000
`define CLK_NS 10
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
// Reset values
`define SPEED_RST 32'h000003E8
`define START_RST 32'h00000064
`endif

// file: move_profile_gen.v
// Stepper move profile generator with APB register access.
// Assumes one 100 MHz clock; host writes a move then sets the go bit.
`timescale 1ns/10ps
`include "move_profile_defs.vh"
module move_profile_gen #(
	parameter TICK_CYCLES = `TICK_CYCLES,
	parameter CLK_HZ = 100000000
)(
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Power stage
	output wire step_out,
	output reg dir_cw
);
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_CHECK = 6'h02;
	localparam [5:0] S_ACC = 6'h04;
	localparam [5:0] S_CRUISE = 6'h08;
	localparam [5:0] S_DEC = 6'h10;
	localparam [5:0] S_DONE = 6'h20;

	reg [5:0] state_reg;
	reg [31:0] target_reg, speed_reg, accel_reg, decel_reg, start_reg;
	reg [15:0] jerk_reg;
	reg [31:0] position_reg;
	reg abs_reg, err_reg, homed_reg;
	reg [23:0] remain_reg;
	reg [31:0] rate_reg;
	reg [31:0] acc_now_reg;
	reg [31:0] tick_cnt_reg;
	reg tick;
	reg ramp_down_reg;
	wire step_pulse;
	wire wr_en, rd_en;
	wire go, bad_jerk, bad_rel, bad_abs, bad_start;
	wire signed [32:0] diff;
	wire [31:0] abs_diff;
	wire [31:0] tgt_mag;
	wire [47:0] accel_ss, decel_ss;
	wire [47:0] jerk_full;
	wire [31:0] jerk_ss;
	wire [31:0] accel_sat, decel_sat;
	wire [31:0] dec_step;
	wire [63:0] brake_prod;
	wire [63:0] brake_quot;
	wire [31:0] brake_need;
	wire [31:0] rate_gap;
	wire [63:0] rd_prod;
	wire [63:0] rd_quot;
	wire [31:0] rampdown_span;
	wire [31:0] jerk_step;
	wire preset_ok;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign go = wr_en && paddr == `REG_CTRL && pwdata[`CTRL_GO] &&
		state_reg == S_IDLE;

	// Units: host gives steps/ms/s, profile uses steps/s^2
	assign accel_ss = accel_reg * `ACCEL_SCALE;
	assign decel_ss = decel_reg * `ACCEL_SCALE;
	assign accel_sat = accel_ss[47:32] != 16'h0000 ? 32'hFFFFFFFF :
		accel_ss[31:0];
	assign decel_sat = decel_ss[47:32] != 16'h0000 ? 32'hFFFFFFFF :
		decel_ss[31:0];
	// Jerk in steps/s^3 = param / 100 * accel
	assign jerk_full = (accel_sat * jerk_reg) / `JERK_SCALE;
	assign jerk_ss = jerk_full[47:32] != 16'h0000 ? 32'hFFFFFFFF :
		jerk_full[31:0];
	// Per-tick change of acceleration, at least one so ramps always end
	assign jerk_step = jerk_ss / 1000 == 0 ? 32'h00000001 : jerk_ss / 1000;

	assign bad_jerk = jerk_reg > `JERK_MAX;
	assign tgt_mag = target_reg[31] ? (~target_reg + 32'h00000001) :
		target_reg;
	assign bad_rel = tgt_mag > {8'h00, `TARGET_MAX};
	assign bad_abs = abs_reg && !homed_reg;
	assign bad_start = start_reg == 32'h00000000 ||
		start_reg > {11'h000, `START_MAX} || speed_reg < start_reg ||
		accel_reg == 32'h00000000 || decel_reg == 32'h00000000;

	assign diff = $signed({target_reg[31], target_reg}) -
		$signed({position_reg[31], position_reg});
	assign abs_diff = diff[32] ? (~diff[31:0] + 32'h00000001) : diff[31:0];
	// Preset values outside the reported span are ignored
	assign preset_ok = $signed(pwdata) >= $signed(`POS_MIN) &&
		$signed(pwdata) <= $signed(`POS_MAX);

	// Braking distance (v^2 - vs^2) / (2d), integer steps
	assign rate_gap = rate_reg - start_reg;
	assign brake_prod = rate_gap * (rate_reg + start_reg);
	// Divide at full width: squared speeds overflow 32 bits on fast moves
	assign brake_quot = brake_prod / {31'h00000000, decel_sat, 1'b0};
	assign brake_need = brake_quot[63:32] != 32'h00000000 ? 32'hFFFFFFFF :
		brake_quot[31:0];
	// Speed gained while acceleration ramps from a to 0: a^2/(2j)
	assign rd_prod = acc_now_reg * acc_now_reg;
	assign rd_quot = rd_prod / {31'h00000000, jerk_ss, 1'b0};
	assign rampdown_span = jerk_ss == 32'h00000000 ? 32'h00000000 :
		(rd_quot[63:32] != 32'h00000000 ? 32'hFFFFFFFF :
		rd_quot[31:0]);
	assign dec_step = decel_sat;

	// Fixed profile tick
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt_reg <= 32'h00000000;
			tick <= 1'b0;
		end
		else if (tick_cnt_reg == TICK_CYCLES - 1)
		begin
			tick_cnt_reg <= 32'h00000000;
			tick <= 1'b1;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
			tick <= 1'b0;
		end
	end

	// Register writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			target_reg <= 32'h00000000;
			speed_reg <= `SPEED_RST;
			accel_reg <= 32'h00000001;
			decel_reg <= 32'h00000001;
			jerk_reg <= 16'h0000;
			start_reg <= `START_RST;
			abs_reg <= 1'b0;
		end
		else if (wr_en && state_reg == S_IDLE)
		begin
			case (paddr)
				`REG_TARGET: target_reg <= pwdata;
				`REG_SPEED: speed_reg <= pwdata;
				`REG_ACCEL: accel_reg <= pwdata;
				`REG_DECEL: decel_reg <= pwdata;
				`REG_JERK: jerk_reg <= pwdata[15:0];
				`REG_START: start_reg <= pwdata;
				`REG_CTRL: abs_reg <= pwdata[`CTRL_ABS];
				default: ;
			endcase
		end
	end

	// Read mux
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd_en)
		begin
			case (paddr)
				`REG_CTRL: prdata <= {30'h00000000, abs_reg, 1'b0};
				`REG_TARGET: prdata <= target_reg;
				`REG_SPEED: prdata <= speed_reg;
				`REG_ACCEL: prdata <= accel_reg;
				`REG_DECEL: prdata <= decel_reg;
				`REG_JERK: prdata <= {16'h0000, jerk_reg};
				`REG_START: prdata <= start_reg;
				`REG_STATUS: prdata <= {27'h0000000,
					state_reg == S_CRUISE, homed_reg, dir_cw, err_reg,
					state_reg != S_IDLE};
				`REG_POSITION: prdata <= position_reg;
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// Profile state machine
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= S_IDLE;
			err_reg <= 1'b0;
			homed_reg <= 1'b0;
			dir_cw <= 1'b1;
			remain_reg <= 24'h000000;
			rate_reg <= 32'h00000000;
			acc_now_reg <= 32'h00000000;
			ramp_down_reg <= 1'b0;
			position_reg <= 32'h00000000;
		end
		else
		begin
			// Position follows every emitted step
			if (step_pulse && remain_reg != 24'h000000)
			begin
				remain_reg <= remain_reg - 24'h000001;
				if (dir_cw)
					position_reg <= position_reg == `POS_MAX ?
						`POS_MIN : position_reg + 32'h00000001;
				else
					position_reg <= position_reg == `POS_MIN ?
						`POS_MAX : position_reg - 32'h00000001;
			end
			case (state_reg)
				S_IDLE:
				begin
					if (wr_en && paddr == `REG_PRESET && preset_ok)
					begin
						position_reg <= pwdata;
						homed_reg <= 1'b1;
					end
					if (wr_en && paddr == `REG_CTRL && pwdata[`CTRL_CLR_ERR])
						err_reg <= 1'b0;
					if (go)
						state_reg <= S_CHECK;
				end
				S_CHECK:
				begin
					// Whole move validated before any step
					if (bad_jerk || bad_rel || bad_abs || bad_start ||
						(abs_reg && abs_diff > {8'h00, `TARGET_MAX}))
					begin
						err_reg <= 1'b1;
						state_reg <= S_IDLE;
					end
					else
					begin
						err_reg <= 1'b0;
						dir_cw <= abs_reg ? !diff[32] : !target_reg[31];
						remain_reg <= abs_reg ? abs_diff[23:0] : tgt_mag[23:0];
						rate_reg <= start_reg;
						acc_now_reg <= jerk_reg == 16'h0000 ? accel_sat :
							32'h00000000;
						ramp_down_reg <= 1'b0;
						state_reg <= (abs_reg ? abs_diff == 32'h00000000 :
							tgt_mag == 32'h00000000) ? S_DONE : S_ACC;
					end
				end
				S_ACC:
				begin
					if (remain_reg <= brake_need[23:0] ||
						brake_need[31:24] != 8'h00)
						state_reg <= S_DEC;
					else if (rate_reg >= speed_reg)
					begin
						rate_reg <= speed_reg;
						state_reg <= S_CRUISE;
					end
					else if (tick)
					begin
						if (jerk_reg != 16'h0000)
						begin
							// Begin ramp-down when speed left fits a^2/2j
							if (ramp_down_reg ||
								speed_reg - rate_reg <= rampdown_span)
							begin
								ramp_down_reg <= 1'b1;
								acc_now_reg <= acc_now_reg > jerk_step ?
									acc_now_reg - jerk_step :
									32'h00000000;
							end
							else if (acc_now_reg < accel_sat)
								acc_now_reg <= accel_sat - acc_now_reg >
									jerk_step ? acc_now_reg +
									jerk_step : accel_sat;
						end
						// Ensure progress when acceleration ramps out early
						rate_reg <= rate_reg + (acc_now_reg / 1000 == 0 ?
							32'h00000001 : acc_now_reg / 1000);
					end
				end
				S_CRUISE:
				begin
					if (remain_reg <= brake_need[23:0] ||
						brake_need[31:24] != 8'h00)
						state_reg <= S_DEC;
				end
				S_DEC:
				begin
					if (remain_reg == 24'h000000)
						state_reg <= S_DONE;
					// Deceleration never drops below the starting speed
					else if (tick)
						rate_reg <= rate_reg - start_reg > dec_step / 1000 ?
							rate_reg - dec_step / 1000 : start_reg;
				end
				S_DONE:
				begin
					rate_reg <= 32'h00000000;
					state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	step_rate_nco #(
		.CLK_HZ(CLK_HZ)
	) u_nco (
		.pclk(pclk),
		.presetn(presetn),
		.run((state_reg == S_ACC || state_reg == S_CRUISE ||
			state_reg == S_DEC) && remain_reg != 24'h000000),
		.rate(rate_reg > {11'h000, `START_MAX} ? `START_MAX : rate_reg[20:0]),
		.step_pulse(step_pulse)
	);

	assign step_out = step_pulse;
endmodule

// file: move_profile_gen_asserts.sv
// Port checker for the move profile generator.
// Bound to the top module by the testbench; one clock domain.
`timescale 1ns/10ps
module move_profile_gen_asserts (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Power stage
	input wire step_out,
	input wire dir_cw
);
	reg [31:0] tgt_reg;
	reg [31:0] cnt_reg;
	reg dir_exp_reg;
	wire wr = psel & penable & pwrite;
	wire rd = psel & penable & ~pwrite;
	wire go = wr & (paddr == 8'h00) & pwdata[0];
	// Shadow of target, step count and the direction a move must take
	always @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		tgt_reg <= 32'h00000000;
		cnt_reg <= 32'h00000000;
		dir_exp_reg <= 1'b1;
	end
	else
	begin
		if (wr && paddr == 8'h04)
			tgt_reg <= pwdata;
		if (wr && paddr == 8'h24)
			cnt_reg <= pwdata;
		else if (step_out)
			cnt_reg <= dir_cw ? cnt_reg + 32'h1 : cnt_reg - 32'h1;
		if (go)
			dir_exp_reg <= pwdata[1] ?
				($signed(tgt_reg) > $signed(cnt_reg)) : ~tgt_reg[31];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_high: assert property (psel |-> pready)
		else $error("pready low during transfer");
	a_no_slverr: assert property (psel && penable |-> !pslverr)
		else $error("pslverr raised");
	a_step_single: assert property ($rose(step_out) |=> !step_out)
		else $error("step pulse longer than one cycle");
	a_dir_steady: assert property (step_out |-> $stable(dir_cw))
		else $error("direction changed at a step");
	a_go_check: assert property (go |=> !step_out [*2])
		else $error("step before profile check");
	a_dir_target: assert property (step_out |-> dir_cw == dir_exp_reg)
		else $error("step direction disagrees with target");
	a_unmapped_zero: assert property (rd && paddr > 8'h24 |-> prdata == 0)
		else $error("unmapped read not zero");
	a_pos_read: assert property (rd && paddr == 8'h20 |-> prdata == $past(cnt_reg))
		else $error("position differs from step count");
endmodule

// file: step_rate_nco.v
// Step pulse generator: phase accumulator driven by a rate in steps/s.
// Assumes pclk at the rate given by clk_hz; run is from same domain.
`timescale 1ns/10ps
module step_rate_nco #(
	parameter CLK_HZ = 100000000
)(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control
	input wire run,
	input wire [20:0] rate,
	// Step output
	output reg step_pulse
);
	reg [27:0] phase_reg;
	wire [28:0] sum;

	assign sum = {1'b0, phase_reg} + {8'h00, rate};

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_reg <= 28'h0000000;
			step_pulse <= 1'b0;
		end
		else if (!run)
		begin
			phase_reg <= 28'h0000000;
			step_pulse <= 1'b0;
		end
		else if (sum >= CLK_HZ)
		begin
			phase_reg <= sum[27:0] - CLK_HZ[27:0];
			step_pulse <= 1'b1;
		end
		else
		begin
			phase_reg <= sum[27:0];
			step_pulse <= 1'b0;
		end
	end
endmodule

// file: stepper_stage_model.sv
// Power stage model: integrates step pulses into net motor travel.
// Assumes step and direction come from the pclk domain.
`timescale 1ns/10ps
module stepper_stage_model (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Step and direction
	input wire step_out,
	input wire dir_cw,
	// Net travel at the shaft
	output reg [31:0] travel
);
	always @(posedge pclk or negedge presetn)
	if (!presetn)
		travel <= 32'h00000000;
	else if (step_out)
		travel <= dir_cw ? travel + 32'h1 : travel - 32'h1;
endmodule

// file: tb_move_profile_gen.sv
// Testbench: APB host issuing moves, power stage model on the far side.
// Assumes a slow step clock; the tick stays CLK_HZ/1000 cycles (1 ms).
`timescale 1ns/10ps
`include "move_profile_defs.vh"
module tb_move_profile_gen;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h00000000;
	wire [31:0] prdata;
	wire pready, pslverr, step_out, dir_cw;
	wire [31:0] travel;
	reg [31:0] rdata;
	reg cruise_seen;
	int n_mismatch = 0;
	int n_compared = 0;
	int k;
	logic [31:0] jk [3] = '{32'h0, 32'h1, 32'h1388};
	logic [7:0] bad_a [3] = '{`REG_JERK, `REG_START, `REG_START};
	logic [31:0] bad_v [3] = '{32'h1389, 32'h0, 32'h1E8480};
	logic [31:0] good_v [3] = '{32'h0, 32'h64, 32'h64};
	always #5 pclk = ~pclk;
	move_profile_gen #(.TICK_CYCLES(10), .CLK_HZ(10000)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .step_out(step_out),
		.dir_cw(dir_cw));
	stepper_stage_model motor (.pclk(pclk), .presetn(presetn),
		.step_out(step_out), .dir_cw(dir_cw), .travel(travel));
	task apb(input bit w, input [7:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task rchk(input string nm, input [7:0] a, input [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rdata, exp);
	endtask
	// Polls status until idle, noting whether cruise was seen
	task wait_idle;
		int i;
		i = 0;
		cruise_seen = 1'b0;
		apb(1'b0, `REG_STATUS, 32'h0);
		while (rdata[`ST_BUSY] === 1'b1 && i < 3000)
		begin
			if (rdata[`ST_CRUISE] === 1'b1)
				cruise_seen = 1'b1;
			apb(1'b0, `REG_STATUS, 32'h0);
			i++;
		end
		chk("busy", {31'h0, rdata[`ST_BUSY]}, 32'h0);
	endtask
	task move(input [31:0] tgt, input [31:0] ctl);
		apb(1'b1, `REG_TARGET, tgt);
		apb(1'b1, `REG_CTRL, ctl);
		wait_idle;
	endtask
	task end_sim;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge pclk);
		n_mismatch++;
		end_sim;
	end
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk("speed", `REG_SPEED, `SPEED_RST);
		rchk("start", `REG_START, `START_RST);
		rchk("accel", `REG_ACCEL, 32'h1);
		rchk("jerk", `REG_JERK, 32'h0);
		rchk("unmapped", 8'h28, 32'h0);
		apb(1'b1, `REG_ACCEL, 32'h64);
		apb(1'b1, `REG_DECEL, 32'h64);
		move(32'h28, 32'h1);
		rchk("pos fwd", `REG_POSITION, 32'h28);
		move(32'hFFFFFFE7, 32'h1);
		rchk("pos back", `REG_POSITION, 32'hF);
		move(32'h0, 32'h3);
		chk("unhomed", rdata & 32'h2, 32'h2);
		apb(1'b1, `REG_CTRL, 32'h8);
		apb(1'b1, `REG_PRESET, 32'h3E8);
		move(32'h3D4, 32'h3);
		chk("abs ok", rdata & 32'hA, 32'h8);
		rchk("pos abs", `REG_POSITION, 32'h3D4);
		move(32'h800000, 32'h3);
		chk("abs far", rdata & 32'h2, 32'h2);
		apb(1'b1, `REG_CTRL, 32'h8);
		move(32'h800000, 32'h1);
		chk("rel far", rdata & 32'h2, 32'h2);
		apb(1'b1, `REG_CTRL, 32'h8);
		rchk("pos kept", `REG_POSITION, 32'h3D4);
		for (k = 0; k < 3; k++)
		begin
			apb(1'b1, `REG_JERK, jk[k]);
			move(32'h14, 32'h1);
			chk("jerk ok", rdata & 32'h2, 32'h0);
		end
		rchk("pos jerk", `REG_POSITION, 32'h410);
		for (k = 0; k < 3; k++)
		begin
			apb(1'b1, bad_a[k], bad_v[k]);
			move(32'h14, 32'h1);
			chk("bad cfg", rdata & 32'h2, 32'h2);
			apb(1'b1, `REG_CTRL, 32'h8);
			apb(1'b1, bad_a[k], good_v[k]);
		end
		apb(1'b1, `REG_SPEED, 32'h12C);
		apb(1'b1, `REG_TARGET, 32'h3C);
		apb(1'b1, `REG_CTRL, 32'h1);
		apb(1'b1, `REG_SPEED, 32'h1F4);
		wait_idle;
		chk("cruise", {31'h0, cruise_seen}, 32'h1);
		rchk("busy wr", `REG_SPEED, 32'h12C);
		apb(1'b1, `REG_SPEED, 32'h7D0);
		move(32'hA, 32'h1);
		chk("no cruise", {31'h0, cruise_seen}, 32'h0);
		rchk("pos end", `REG_POSITION, 32'h456);
		chk("travel", travel, 32'h7D);
		end_sim;
	end
endmodule
bind move_profile_gen move_profile_gen_asserts chk_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .step_out(step_out), .dir_cw(dir_cw));
